/* File: bench/frequency_set_point_select_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.svh"
module frequency_set_point_select_tb_top;
    localparam int SHORT_CYC = 4;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [5:0] req_addr_in = 6'h00;
    logic [7:0] req_wdata_in = 8'h00;
    logic switch_in = 1'b0;
    logic [7:0] vref_from_in = 8'h00;
    logic [7:0] vref_to_in = 8'h00;
    logic req_ready_out, rd_valid_out, busy_out;
    logic [7:0] rd_data_out;
    fsp_pkg::fsp_copy_type active_out;
    logic [1:0] burst_len_out;
    logic op_point_out, write_set_out, vref_boost_out;
    logic clock_change_ok_out;
    int num_errors = 0;
    int checked = 0;
    int seed = 32'h8982;
    fsp_pkg::fsp_byte_type exp_q[$];
    fsp_pkg::fsp_byte_type wd[7];
    fsp_pkg::fsp_addr_type addr_t[7] = '{`FSP_ADDR_BURST_PREAMBLE, `FSP_ADDR_LATENCY,
        `FSP_ADDR_IO_CONFIG, `FSP_ADDR_TERMINATION, `FSP_ADDR_CMD_VREF,
        `FSP_ADDR_DATA_VREF, `FSP_ADDR_HOST_TERMINATION};
    fsp_pkg::fsp_byte_type mask_t[7] = '{`FSP_MASK_BURST_PREAMBLE, `FSP_MASK_LATENCY,
        `FSP_MASK_IO_CONFIG, `FSP_MASK_TERMINATION, `FSP_MASK_VREF, `FSP_MASK_VREF,
        `FSP_MASK_HOST_TERMINATION};
    fsp_pkg::fsp_byte_type rst_t[7] = '{`FSP_RST_BURST_PREAMBLE, `FSP_RST_LATENCY,
        `FSP_RST_IO_CONFIG, `FSP_RST_TERMINATION, `FSP_RST_VREF, `FSP_RST_VREF,
        `FSP_RST_HOST_TERMINATION};

    fsp_if bus_if();
    fsp_device i_fsp_device (.clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
        .bus(bus_if), .active_out(active_out), .burst_len_out(burst_len_out),
        .op_point_out(op_point_out), .write_set_out(write_set_out),
        .vref_boost_out(vref_boost_out));
    fsp_controller #(.SHORT_CYC(SHORT_CYC), .MIDDLE_CYC(SHORT_CYC), .LONG_CYC(6),
        .GUARD_CYC(4)) i_fsp_controller (.clk_in(clk_in), .resetn_in(resetn_in),
        .clk_en_in(1'b1), .bus(bus_if), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
        .switch_in(switch_in), .vref_from_in(vref_from_in), .vref_to_in(vref_to_in),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .busy_out(busy_out),
        .clock_change_ok_out(clock_change_ok_out));
    fsp_chk #(.SHORT_CYC(SHORT_CYC)) i_fsp_chk (.clk_in(clk_in), .resetn_in(resetn_in),
        .cmd_valid(bus_if.cmd_valid), .cmd_write(bus_if.cmd_write),
        .cmd_addr(bus_if.cmd_addr), .cmd_wdata(bus_if.cmd_wdata),
        .rd_data(bus_if.rd_data), .rd_valid(bus_if.rd_valid));

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // read data monitor
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (rd_valid_out === 1'b1) begin
            check(rd_data_out, (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data_out);
        end
    end

    task automatic send(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b1;
        req_write_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        while (req_ready_out !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n >= 100) num_errors++;
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b0;
    endtask : send

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        send(1'b0, a, 8'h00);
    endtask : rd

    task automatic chk_active(input fsp_pkg::fsp_byte_type v[7]);
        for (int i = 0; i < 7; i++) begin
            check(active_out[8*(6-i) +: 8] & mask_t[i], v[i] & mask_t[i]);
        end
    endtask : chk_active

    task automatic do_switch(input logic [7:0] from, input logic [7:0] to, input logic pt);
        int n;
        int hi;
        int ok;
        n = 0;
        hi = 0;
        ok = 0;
        @(posedge clk_in);
        #1;
        switch_in = 1'b1;
        vref_from_in = from;
        vref_to_in = to;
        while (busy_out !== 1'b1 && n < 50) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        switch_in = 1'b0;
        while (busy_out === 1'b1 && n < 500) begin
            @(posedge clk_in);
            #1;
            n++;
            if (vref_boost_out === 1'b1) hi++;
            if (clock_change_ok_out === 1'b1) ok++;
        end
        check({7'h00, ok >= SHORT_CYC}, 8'h01);
        check({7'h00, op_point_out}, {7'h00, pt});
        check({7'h00, vref_boost_out}, 8'h00);
        check({7'h00, hi >= SHORT_CYC}, 8'h01);
        $display("switch to point %0d done", pt);
    endtask : do_switch

    initial begin
        repeat (2) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        chk_active(rst_t);
        check({6'h00, op_point_out, write_set_out}, 8'h00);
        $display("reset state done");
        send(1'b1, `FSP_ADDR_SET_CONTROL, 8'h40);
        rd(`FSP_ADDR_SET_CONTROL, 8'h40);
        for (int i = 0; i < 7; i++) begin
            wd[i] = 8'($random(seed));
            send(1'b1, addr_t[i], wd[i]);
        end
        for (int i = 0; i < 7; i++) begin
            rd(addr_t[i], wd[i] & ((i == 0 || i == 2) ? 8'hFF : mask_t[i]));
        end
        check({7'h00, write_set_out}, 8'h01);
        chk_active(rst_t);
        rd(6'h3F, 8'h00);
        $display("alternate copy written");
        do_switch(`FSP_RST_VREF, wd[4], 1'b1);
        chk_active(wd);
        check({6'h00, burst_len_out}, {6'h00, wd[0][1:0]});
        for (int i = 0; i < 7; i++) begin
            rd(addr_t[i], (i == 2) ? ((wd[i] & ~mask_t[i]) | (rst_t[i] & mask_t[i]))
                : rst_t[i]);
        end
        do_switch(wd[4], `FSP_RST_VREF, 1'b0);
        chk_active(rst_t);
        repeat (4) @(posedge clk_in);
        check(8'(exp_q.size()), 8'h00);
        give_verdict();
    end

    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule : frequency_set_point_select_tb_top
`default_nettype wire

/* File: bench/fsp_chk.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.svh"
module fsp_chk #(
    parameter int SHORT_CYC = 4
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [5:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    // ----------------------------------------
    // helper: last set control write, cycles since point flip
    // ----------------------------------------
    logic [7:0] ctl_r;
    int cnt_r;
    logic rd;
    logic wr;
    logic ctl_wr;
    logic flip;
    logic mapped;
    assign rd = cmd_valid && !cmd_write;
    assign wr = cmd_valid && cmd_write;
    assign ctl_wr = wr && (cmd_addr == `FSP_ADDR_SET_CONTROL);
    assign flip = ctl_wr && (cmd_wdata[`FSP_BIT_OP_POINT] != ctl_r[`FSP_BIT_OP_POINT]);
    assign mapped = cmd_addr inside {`FSP_ADDR_BURST_PREAMBLE, `FSP_ADDR_LATENCY,
        `FSP_ADDR_IO_CONFIG, `FSP_ADDR_TERMINATION, `FSP_ADDR_CMD_VREF,
        `FSP_ADDR_SET_CONTROL, `FSP_ADDR_DATA_VREF, `FSP_ADDR_HOST_TERMINATION};
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctl_r <= 8'h00;
            cnt_r <= 0;
        end else begin
            ctl_r <= ctl_wr ? cmd_wdata : ctl_r;
            cnt_r <= flip ? 0 : cnt_r + 1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_rd_answer; rd |=> rd_valid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered one cycle later");
    property p_rd_cause; rd_valid |-> $past(rd); endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read data valid without a read");
    property p_no_rd_on_wr; wr |=> !rd_valid; endproperty
    a_no_rd_on_wr: assert property (p_no_rd_on_wr)
        else $error("read data valid after a write");
    property p_unmapped; rd && !mapped |=> rd_data == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_ctl_read;
        rd && cmd_addr == `FSP_ADDR_SET_CONTROL |=> rd_data == $past(ctl_r);
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("set control read differs from last write");
    property p_boost_flip; flip |-> cmd_wdata[`FSP_BIT_VREF_BOOST]; endproperty
    a_boost_flip: assert property (p_boost_flip)
        else $error("point change without current boost");
    property p_boost_hold;
        ctl_wr && ctl_r[`FSP_BIT_VREF_BOOST] && !cmd_wdata[`FSP_BIT_VREF_BOOST]
            |-> cnt_r >= SHORT_CYC;
    endproperty
    a_boost_hold: assert property (p_boost_hold)
        else $error("boost dropped before switch time");
    property p_quiet; flip |=> !cmd_valid [*3]; endproperty
    a_quiet: assert property (p_quiet)
        else $error("command issued during switch time");
    c_read: cover property (rd ##1 rd_valid);
    c_flip: cover property (flip);
    c_unmapped: cover property (rd && !mapped);
endmodule : fsp_chk
`default_nettype wire

/* File: hdl/fsp_controller.sv */
`include "fsp_map.svh"
`timescale 1ns/100ps
`default_nettype none
module fsp_controller #(
    parameter int SHORT_CYC = `FSP_SWITCH_SHORT_CYC,
    parameter int MIDDLE_CYC = `FSP_SWITCH_MIDDLE_CYC,
    parameter int LONG_CYC = `FSP_SWITCH_LONG_CYC,
    parameter int GUARD_CYC = `FSP_GUARD_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    fsp_if.ctrl bus,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [5:0] req_addr_in,
    input wire logic [7:0] req_wdata_in,
    output logic req_ready_out,
    input wire logic switch_in,
    input wire logic [7:0] vref_from_in,
    input wire logic [7:0] vref_to_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic busy_out,
    output logic clock_change_ok_out
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SWITCH,
        ST_WAIT,
        ST_RELEASE,
        ST_GUARD
    } fsp_ctl_st_type;

    typedef struct packed {
        fsp_ctl_st_type st;
        logic [15:0] cnt;
        logic op_point;
        logic cmd_valid;
        logic cmd_write;
        logic [5:0] cmd_addr;
        logic [7:0] cmd_wdata;
        logic [7:0] rd_data;
        logic rd_valid;
    } fsp_ctl_state_type;

    fsp_ctl_state_type state_r;
    fsp_ctl_state_type state_nxt;
    fsp_pkg::fsp_case_type sw_case;
    logic [5:0] step;
    logic [15:0] wait_cyc;

    // ------------------------------------------------------------
    // switch case selection
    // ------------------------------------------------------------
    always_comb begin
        step = (vref_to_in[5:0] > vref_from_in[5:0]) ? vref_to_in[5:0] - vref_from_in[5:0]
                                                    : vref_from_in[5:0] - vref_to_in[5:0];
        if (vref_to_in[`FSP_BIT_VREF_RANGE] != vref_from_in[`FSP_BIT_VREF_RANGE]) begin
            sw_case = fsp_pkg::FSP_CASE_LONG;
        end else if (step > 6'h01) begin
            sw_case = fsp_pkg::FSP_CASE_MIDDLE;
        end else begin
            sw_case = fsp_pkg::FSP_CASE_SHORT;
        end
        case (sw_case)
            fsp_pkg::FSP_CASE_LONG: wait_cyc = 16'(LONG_CYC);
            fsp_pkg::FSP_CASE_MIDDLE: wait_cyc = 16'(MIDDLE_CYC);
            default: wait_cyc = 16'(SHORT_CYC);
        endcase
    end

    assign req_ready_out = (state_r.st == ST_IDLE) && !switch_in;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.cmd_valid = 1'b0;
        state_nxt.rd_valid = bus.rd_valid;
        if (bus.rd_valid) begin
            state_nxt.rd_data = bus.rd_data;
        end
        case (state_r.st)
            ST_IDLE: begin
                if (switch_in) begin
                    state_nxt.st = ST_SWITCH;
                end else if (req_valid_in) begin
                    state_nxt.cmd_valid = 1'b1;
                    state_nxt.cmd_write = req_write_in;
                    state_nxt.cmd_addr = req_addr_in;
                    state_nxt.cmd_wdata = req_wdata_in;
                    if (req_write_in && req_addr_in == `FSP_ADDR_SET_CONTROL) begin
                        state_nxt.op_point = req_wdata_in[`FSP_BIT_OP_POINT];
                    end
                end
            end
            ST_SWITCH: begin
                state_nxt.op_point = !state_r.op_point;
                state_nxt.cmd_valid = 1'b1;
                state_nxt.cmd_write = 1'b1;
                state_nxt.cmd_addr = `FSP_ADDR_SET_CONTROL;
                state_nxt.cmd_wdata = 8'h00;
                state_nxt.cmd_wdata[`FSP_BIT_OP_POINT] = !state_r.op_point;
                state_nxt.cmd_wdata[`FSP_BIT_WRITE_SET] = state_r.op_point;
                state_nxt.cmd_wdata[`FSP_BIT_VREF_BOOST] = 1'b1;
                state_nxt.cnt = wait_cyc;
                state_nxt.st = ST_WAIT;
            end
            ST_WAIT: begin
                // data vref covered by same wait
                if (state_r.cnt <= 16'h0001) begin
                    state_nxt.st = ST_RELEASE;
                end else begin
                    state_nxt.cnt = state_r.cnt - 16'h0001;
                end
            end
            ST_RELEASE: begin
                state_nxt.cmd_valid = 1'b1;
                state_nxt.cmd_write = 1'b1;
                state_nxt.cmd_addr = `FSP_ADDR_SET_CONTROL;
                state_nxt.cmd_wdata = 8'h00;
                state_nxt.cmd_wdata[`FSP_BIT_OP_POINT] = state_r.op_point;
                state_nxt.cmd_wdata[`FSP_BIT_WRITE_SET] = !state_r.op_point;
                state_nxt.cnt = 16'(GUARD_CYC);
                state_nxt.st = ST_GUARD;
            end
            ST_GUARD: begin
                if (state_r.cnt <= 16'h0001) begin
                    state_nxt.st = ST_IDLE;
                end else begin
                    state_nxt.cnt = state_r.cnt - 16'h0001;
                end
            end
            default: state_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r.st <= ST_IDLE;
            state_r.cnt <= 16'h0000;
            state_r.op_point <= 1'b0;
            state_r.cmd_valid <= 1'b0;
            state_r.cmd_write <= 1'b0;
            state_r.cmd_addr <= 6'h00;
            state_r.cmd_wdata <= 8'h00;
            state_r.rd_data <= 8'h00;
            state_r.rd_valid <= 1'b0;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
        end
    end

    assign bus.cmd_valid = state_r.cmd_valid;
    assign bus.cmd_write = state_r.cmd_write;
    assign bus.cmd_addr = state_r.cmd_addr;
    assign bus.cmd_wdata = state_r.cmd_wdata;
    assign rd_data_out = state_r.rd_data;
    assign rd_valid_out = state_r.rd_valid;
    assign busy_out = state_r.st != ST_IDLE;
    assign clock_change_ok_out = (state_r.st == ST_WAIT) && clk_en_in;

endmodule : fsp_controller
`default_nettype wire

/* File: hdl/fsp_device.sv */
`include "fsp_map.svh"
//
// Function
// - two copies of every duplicated parameter
// - write select picks copy for access
// - operating bit picks running copy
// - write select and operating independent
// - new copy applied whole, within switch time
// - burst preamble register fields duplicated
// - latency register fields duplicated
// - io config register fields duplicated
// - termination and both vref registers duplicated
// - host termination fields duplicated
// - burst length duplication is an option
// - controller writes same burst length both; fsp_controller only forwards req writes as given
// - controller matches pullup point across channels; fsp_controller drives one bus and sets no pullup point
// - boost vref current with point change
// - drop boost only after switch time
// - change clock only with enable high
// - wait switch time, 200 or 250 ns
// - case from vref step and range
// - valid clock after point change; clock_change_ok_out rises in the cycle the switch write is issued
// - valid clock before first command
// - data vref settles like command vref
// - power up on copy zero, defaults
// - single write switches trained points
`timescale 1ns/100ps
`default_nettype none
module fsp_device #(
    parameter bit DUP_BURST_LEN = 1'b1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    fsp_if.dev bus,
    output fsp_pkg::fsp_copy_type active_out,
    output logic [1:0] burst_len_out,
    output logic op_point_out,
    output logic write_set_out,
    output logic vref_boost_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fsp_pkg::fsp_copy_type [1:0] copy;
        logic [1:0][1:0] burst_len;
        fsp_pkg::fsp_byte_type shared_burst;
        fsp_pkg::fsp_byte_type shared_io;
        fsp_pkg::fsp_byte_type set_control;
        fsp_pkg::fsp_copy_type active;
        logic [1:0] active_burst;
        fsp_pkg::fsp_byte_type rd_data;
        logic rd_valid;
    } fsp_dev_state_type;

    fsp_dev_state_type state_r;
    fsp_dev_state_type state_nxt;

    logic wsel;
    logic opsel;
    fsp_pkg::fsp_byte_type rd_mux;
    fsp_pkg::fsp_byte_type wd;

    assign wsel = state_r.set_control[`FSP_BIT_WRITE_SET];
    assign opsel = state_r.set_control[`FSP_BIT_OP_POINT];
    assign wd = bus.cmd_wdata;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        case (bus.cmd_addr)
            `FSP_ADDR_BURST_PREAMBLE: begin
                rd_mux = (state_r.copy[wsel].burst_preamble & `FSP_MASK_BURST_PREAMBLE)
                    | (DUP_BURST_LEN ? {6'h00, state_r.burst_len[wsel]}
                                     : (state_r.shared_burst & `FSP_MASK_BURST_LEN));
            end
            `FSP_ADDR_LATENCY: rd_mux = state_r.copy[wsel].latency;
            `FSP_ADDR_IO_CONFIG: begin
                rd_mux = state_r.copy[wsel].io_config
                    | (state_r.shared_io & ~`FSP_MASK_IO_CONFIG);
            end
            `FSP_ADDR_TERMINATION: rd_mux = state_r.copy[wsel].termination;
            `FSP_ADDR_CMD_VREF: rd_mux = state_r.copy[wsel].cmd_vref;
            `FSP_ADDR_DATA_VREF: rd_mux = state_r.copy[wsel].data_vref;
            `FSP_ADDR_HOST_TERMINATION: rd_mux = state_r.copy[wsel].host_termination;
            `FSP_ADDR_SET_CONTROL: rd_mux = state_r.set_control;
            default: rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.rd_valid = 1'b0;
        if (bus.cmd_valid && !bus.cmd_write) begin
            state_nxt.rd_data = rd_mux;
            state_nxt.rd_valid = 1'b1;
        end
        if (bus.cmd_valid && bus.cmd_write) begin
            case (bus.cmd_addr)
                `FSP_ADDR_BURST_PREAMBLE: begin
                    state_nxt.copy[wsel].burst_preamble = wd & `FSP_MASK_BURST_PREAMBLE;
                    if (DUP_BURST_LEN) begin
                        state_nxt.burst_len[wsel] = wd[1:0];
                    end else begin
                        state_nxt.shared_burst = wd & `FSP_MASK_BURST_LEN;
                    end
                end
                `FSP_ADDR_LATENCY: state_nxt.copy[wsel].latency = wd & `FSP_MASK_LATENCY;
                `FSP_ADDR_IO_CONFIG: begin
                    state_nxt.copy[wsel].io_config = wd & `FSP_MASK_IO_CONFIG;
                    state_nxt.shared_io = wd & ~`FSP_MASK_IO_CONFIG;
                end
                `FSP_ADDR_TERMINATION: state_nxt.copy[wsel].termination = wd & `FSP_MASK_TERMINATION;
                `FSP_ADDR_CMD_VREF: state_nxt.copy[wsel].cmd_vref = wd & `FSP_MASK_VREF;
                `FSP_ADDR_DATA_VREF: state_nxt.copy[wsel].data_vref = wd & `FSP_MASK_VREF;
                `FSP_ADDR_HOST_TERMINATION: begin
                    state_nxt.copy[wsel].host_termination = wd & `FSP_MASK_HOST_TERMINATION;
                end
                `FSP_ADDR_SET_CONTROL: state_nxt.set_control = wd;
                default: state_nxt.rd_valid = state_nxt.rd_valid;
            endcase
        end
        // whole copy loaded in one edge
        state_nxt.active = state_r.copy[opsel];
        state_nxt.active_burst = DUP_BURST_LEN ? state_r.burst_len[opsel]
                                               : state_r.shared_burst[1:0];
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r.copy[0] <= {`FSP_RST_BURST_PREAMBLE, `FSP_RST_LATENCY, `FSP_RST_IO_CONFIG,
                `FSP_RST_TERMINATION, `FSP_RST_VREF, `FSP_RST_VREF, `FSP_RST_HOST_TERMINATION};
            state_r.copy[1] <= {`FSP_RST_BURST_PREAMBLE, `FSP_RST_LATENCY, `FSP_RST_IO_CONFIG,
                `FSP_RST_TERMINATION, `FSP_RST_VREF, `FSP_RST_VREF, `FSP_RST_HOST_TERMINATION};
            state_r.burst_len <= 4'h0;
            state_r.shared_burst <= 8'h00;
            state_r.shared_io <= `FSP_RST_IO_CONFIG & ~`FSP_MASK_IO_CONFIG;
            state_r.set_control <= `FSP_RST_SET_CONTROL;
            state_r.active <= {`FSP_RST_BURST_PREAMBLE, `FSP_RST_LATENCY, `FSP_RST_IO_CONFIG,
                `FSP_RST_TERMINATION, `FSP_RST_VREF, `FSP_RST_VREF, `FSP_RST_HOST_TERMINATION};
            state_r.active_burst <= 2'h0;
            state_r.rd_data <= 8'h00;
            state_r.rd_valid <= 1'b0;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
        end
    end

    assign bus.rd_data = state_r.rd_data;
    assign bus.rd_valid = state_r.rd_valid;
    assign active_out = state_r.active;
    assign burst_len_out = state_r.active_burst;
    assign op_point_out = opsel;
    assign write_set_out = wsel;
    assign vref_boost_out = state_r.set_control[`FSP_BIT_VREF_BOOST];

endmodule : fsp_device
`default_nettype wire

/* File: inc/fsp_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface fsp_if;
    logic cmd_valid;
    logic cmd_write;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic [7:0] rd_data;
    logic rd_valid;
    modport ctrl (
        output cmd_valid,
        output cmd_write,
        output cmd_addr,
        output cmd_wdata,
        input rd_data,
        input rd_valid
    );
    modport dev (
        input cmd_valid,
        input cmd_write,
        input cmd_addr,
        input cmd_wdata,
        output rd_data,
        output rd_valid
    );
endinterface : fsp_if
`default_nettype wire

/* File: inc/fsp_map.svh */
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// mode register addresses
`define FSP_ADDR_BURST_PREAMBLE 6'h01
`define FSP_ADDR_LATENCY 6'h02
`define FSP_ADDR_IO_CONFIG 6'h03
`define FSP_ADDR_TERMINATION 6'h0B
`define FSP_ADDR_CMD_VREF 6'h0C
`define FSP_ADDR_SET_CONTROL 6'h0D
`define FSP_ADDR_DATA_VREF 6'h0E
`define FSP_ADDR_HOST_TERMINATION 6'h16

// duplicated bit masks per register
`define FSP_MASK_BURST_PREAMBLE 8'hFC
`define FSP_MASK_BURST_LEN 8'h03
`define FSP_MASK_LATENCY 8'h7F
`define FSP_MASK_IO_CONFIG 8'hFB
`define FSP_MASK_TERMINATION 8'h77
`define FSP_MASK_VREF 8'h7F
`define FSP_MASK_HOST_TERMINATION 8'h3F

// set control and vref register fields
`define FSP_BIT_VREF_BOOST 3
`define FSP_BIT_WRITE_SET 6
`define FSP_BIT_OP_POINT 7
`define FSP_BIT_VREF_RANGE 6
`define FSP_VREF_SETTING_MSB 5

// reset values (unterminated, low frequency)
`define FSP_RST_BURST_PREAMBLE 8'h00
`define FSP_RST_LATENCY 8'h00
`define FSP_RST_IO_CONFIG 8'h31
`define FSP_RST_TERMINATION 8'h00
`define FSP_RST_VREF 8'h4D
`define FSP_RST_HOST_TERMINATION 8'h00
`define FSP_RST_SET_CONTROL 8'h00

// timing in ns and ps and derived cycle counts at 8 ns
`define FSP_CLK_PERIOD_NS 8
`define FSP_SWITCH_SHORT_NS 200
`define FSP_SWITCH_MIDDLE_NS 200
`define FSP_SWITCH_LONG_NS 250
`define FSP_CLOCK_GUARD_PS 7500
`define FSP_CLOCK_GUARD_NCK 4
`define FSP_SWITCH_SHORT_CYC ((`FSP_SWITCH_SHORT_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_SWITCH_MIDDLE_CYC ((`FSP_SWITCH_MIDDLE_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_SWITCH_LONG_CYC ((`FSP_SWITCH_LONG_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_GUARD_PS_CYC ((`FSP_CLOCK_GUARD_PS + `FSP_CLK_PERIOD_NS * 1000 - 1) / (`FSP_CLK_PERIOD_NS * 1000))
`define FSP_GUARD_CYC ((`FSP_GUARD_PS_CYC > `FSP_CLOCK_GUARD_NCK) ? `FSP_GUARD_PS_CYC : `FSP_CLOCK_GUARD_NCK)
// device applies the new copy within this many cycles
`define FSP_APPLY_CYC 2

`endif

/* File: inc/fsp_pkg.sv */
package fsp_pkg;
    typedef logic [7:0] fsp_byte_type;
    typedef logic [5:0] fsp_addr_type;
    typedef enum logic [1:0] {
        FSP_CASE_SHORT,
        FSP_CASE_MIDDLE,
        FSP_CASE_LONG
    } fsp_case_type;
    // duplicated fields, one per point
    typedef struct packed {
        fsp_byte_type burst_preamble;
        fsp_byte_type latency;
        fsp_byte_type io_config;
        fsp_byte_type termination;
        fsp_byte_type cmd_vref;
        fsp_byte_type data_vref;
        fsp_byte_type host_termination;
    } fsp_copy_type;
endpackage : fsp_pkg
